// file: src/lil_top.sv
// LED indicator: signal combination, latch, acknowledge, colour drive, APB registers
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "lil_cfg.svh"
// Overview of operation
// RULE_01 - Each input has its own invert bit, off after reset.
// RULE_02 - Up to five inputs are ORed; true lights the active colour.
// RULE_03 - Latch bit, off after reset, holds the indication after pickup.
// RULE_04 - Acknowledge clears a held indication only once all inputs have dropped.
// RULE_05 - Acknowledge source acts only while latching is enabled.
// RULE_06 - Active colour: green, red, red flash, green flash; group default.
// RULE_07 - OR false shows the inactive colour, or stays dark if none.
// RULE_08 - Flash modes toggle at a fixed divided rate, half on, half off.
module lil_top #(
    parameter bit          GROUP_B  = 1'b0,
    parameter int unsigned HALF_CYC = `LIL_FLASH_HALF_CYC
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  wire lil_pkg::lil_apb_req_t apb_req,
    output var  lil_pkg::lil_apb_rsp_t apb_rsp,
    input  wire logic [`LIL_NSIG-1:0]  sig_in,
    input  wire logic [`LIL_NACK-1:0]  ack_in,
    output logic                       led_green,
    output logic                       led_red
);
    import lil_pkg::*;

    localparam int unsigned NSIG = `LIL_NSIG;
    localparam int unsigned NACK = `LIL_NACK;
    localparam lil_color_t  ACT_RST = lil_color_t'(GROUP_B ? LIL_RED : LIL_GREEN);

    lil_state_t        st_reg;
    lil_state_t        st_next;
    logic              flash_phase;
    logic [NSIG-1:0]   eff_sig;
    logic              or_now;
    logic              ack_lvl;
    logic              ack_evt;
    logic              ind;
    lil_color_t        show;
    logic [1:0]        paint;
    logic              access;
    logic              fire;
    logic              hit;
    logic              bad;
    logic              wr_fire;
    logic [31:0]       rd_data;

    lil_flash_div #(
        .HALF_CYC (HALF_CYC)
    ) u_flash (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .phase   (flash_phase)
    );

    // Disabled inputs are masked after inversion, so an unused slot never
    // lights the lamp even when its invert bit is set
    assign eff_sig = (sig_in ^ st_reg.inv) & st_reg.en; // see RULE_01
    assign or_now  = |eff_sig; // see RULE_02

    always_comb begin
        ack_lvl = 1'b0;
        for (int i = 0; i < NACK; i++) begin
            if (st_reg.ack_sel == `LIL_ACK_SEL_W'(i + 1)) begin
                ack_lvl = ack_in[i];
            end
        end
    end

    // Rising edge only, so a stuck acknowledge cannot clear a later pickup
    assign ack_evt = st_reg.latch & ack_lvl & ~st_reg.ack_prev; // see RULE_05

    assign ind  = st_reg.latch ? (st_reg.held | or_now) : or_now; // see RULE_03
    assign show = lil_color_t'(ind ? st_reg.act : st_reg.inact); // see RULE_07

    always_comb begin
        case (show)
            LIL_GREEN: begin
                paint = 2'b10; // see RULE_06
            end
            LIL_RED: begin
                paint = 2'b01; // see RULE_06
            end
            LIL_RED_FLASH: begin
                paint = {1'b0, flash_phase}; // see RULE_08
            end
            LIL_GREEN_FLASH: begin
                paint = {flash_phase, 1'b0}; // see RULE_08
            end
            default: begin
                paint = 2'b00; // see RULE_07
            end
        endcase
    end

    assign access = apb_req.psel & apb_req.penable;
    assign fire   = access & st_reg.rsp.pready;

    always_comb begin
        case (apb_req.paddr)
            `LIL_CTRL_OFS: begin
                hit = 1'b1;
            end
            `LIL_COLOR_OFS: begin
                hit = 1'b1;
            end
            `LIL_STAT_OFS: begin
                hit = 1'b1;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // Status is read only; writing it is flagged rather than dropped silently
    assign bad     = ~hit | (apb_req.pwrite & (apb_req.paddr == `LIL_STAT_OFS));
    assign wr_fire = fire & apb_req.pwrite & ~bad;

    always_comb begin
        rd_data = 32'h0000_0000;
        case (apb_req.paddr)
            `LIL_CTRL_OFS: begin
                rd_data[`LIL_CTRL_INV_LSB +: NSIG] = st_reg.inv;
                rd_data[`LIL_CTRL_EN_LSB +: NSIG]  = st_reg.en;
                rd_data[`LIL_CTRL_LATCH_BIT]       = st_reg.latch;
                rd_data[`LIL_CTRL_ACK_LSB +: `LIL_ACK_SEL_W] = st_reg.ack_sel;
            end
            `LIL_COLOR_OFS: begin
                rd_data[`LIL_COLOR_ACT_LSB +: 3]   = st_reg.act;
                rd_data[`LIL_COLOR_INACT_LSB +: 3] = st_reg.inact;
            end
            `LIL_STAT_OFS: begin
                rd_data[`LIL_STAT_OR_BIT]    = or_now;
                rd_data[`LIL_STAT_HELD_BIT]  = st_reg.held;
                rd_data[`LIL_STAT_IND_BIT]   = ind;
                rd_data[`LIL_STAT_GREEN_BIT] = st_reg.green;
                rd_data[`LIL_STAT_RED_BIT]   = st_reg.red;
                rd_data[`LIL_STAT_FLASH_BIT] = flash_phase;
                rd_data[`LIL_STAT_SIG_LSB +: NSIG] = sig_in;
            end
            default: begin
                rd_data = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        st_next = st_reg;
        // One wait state: pready rises in the second access cycle
        st_next.rsp.pready = access & ~st_reg.rsp.pready;
        if (access & ~st_reg.rsp.pready) begin
            st_next.rsp.pslverr = bad;
            st_next.rsp.prdata  = (apb_req.pwrite | bad) ? 32'h0000_0000 : rd_data;
        end else begin
            st_next.rsp.pslverr = 1'b0;
        end
        if (wr_fire && apb_req.paddr == `LIL_CTRL_OFS) begin
            st_next.inv     = apb_req.pwdata[`LIL_CTRL_INV_LSB +: NSIG];
            st_next.en      = apb_req.pwdata[`LIL_CTRL_EN_LSB +: NSIG];
            st_next.latch   = apb_req.pwdata[`LIL_CTRL_LATCH_BIT];
            st_next.ack_sel = apb_req.pwdata[`LIL_CTRL_ACK_LSB +: `LIL_ACK_SEL_W];
        end
        if (wr_fire && apb_req.paddr == `LIL_COLOR_OFS) begin
            st_next.act   = lil_color_t'(apb_req.pwdata[`LIL_COLOR_ACT_LSB +: 3]);
            st_next.inact = lil_color_t'(apb_req.pwdata[`LIL_COLOR_INACT_LSB +: 3]);
        end
        // Pickup wins over an acknowledge in the same cycle
        if (!st_reg.latch) begin
            st_next.held = 1'b0; // see RULE_03
        end else if (or_now) begin
            st_next.held = 1'b1; // see RULE_04
        end else if (ack_evt) begin
            st_next.held = 1'b0; // see RULE_04
        end
        st_next.ack_prev = ack_lvl;
        st_next.green    = paint[1];
        st_next.red      = paint[0];
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg          <= '0;
            st_reg.inv      <= `LIL_INV_RST; // see RULE_01
            st_reg.en       <= `LIL_EN_RST;
            st_reg.latch    <= `LIL_LATCH_RST; // see RULE_03
            st_reg.ack_sel  <= `LIL_ACK_SEL_RST;
            st_reg.act      <= ACT_RST; // see RULE_06
            st_reg.inact    <= LIL_OFF; // see RULE_07
        end else begin
            st_reg <= st_next;
        end
    end

    assign apb_rsp   = st_reg.rsp;
    assign led_green = st_reg.green;
    assign led_red   = st_reg.red;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_invert_lights: assert property ( // see RULE_01
        !st_reg.latch && st_reg.act == LIL_GREEN && st_reg.en[0] && st_reg.inv[0]
        && !sig_in[0] && !wr_fire |=> led_green && !led_red
    ) else $error("inverted low input did not light the active colour");

    a_or_active_red: assert property ( // see RULE_02
        !st_reg.latch && st_reg.act == LIL_RED && (|((sig_in ^ st_reg.inv) & st_reg.en))
        && !wr_fire |=> led_red && !led_green
    ) else $error("OR result true but active red not shown");

    a_latch_holds: assert property ( // see RULE_03
        st_reg.latch && st_reg.held && !ack_evt && !wr_fire |=> st_reg.held
    ) else $error("held indication dropped without acknowledge");

    a_latch_pickup: assert property ( // see RULE_03
        st_reg.latch && or_now && !wr_fire |=> st_reg.held ##1 (st_reg.held || !st_reg.latch
        || $past(ack_evt))
    ) else $error("latched pickup not held");

    a_ack_ignored: assert property ( // see RULE_04
        st_reg.latch && st_reg.held && or_now && ack_evt && !wr_fire |=> st_reg.held
    ) else $error("acknowledge cleared while inputs still present");

    a_ack_clears: assert property ( // see RULE_04
        st_reg.latch && st_reg.held && !or_now && ack_evt && !wr_fire |=> !st_reg.held
    ) else $error("acknowledge with inputs dropped did not clear");

    a_nolatch_follow: assert property ( // see RULE_05
        !st_reg.latch && !or_now && st_reg.inact == LIL_OFF && !wr_fire
        |=> !st_reg.held && !led_green && !led_red
    ) else $error("acknowledge or hold acted with latching off");

    a_green_steady: assert property ( // see RULE_06
        ind && st_reg.act == LIL_GREEN && !wr_fire [*2] |=> led_green && !led_red
    ) else $error("steady green active colour not shown");

    a_inactive_colour: assert property ( // see RULE_07
        !ind && st_reg.inact == LIL_RED && !wr_fire |=> led_red && !led_green
    ) else $error("inactive colour not shown while OR false");

    a_flash_follows: assert property ( // see RULE_08
        ind && st_reg.act == LIL_RED_FLASH && !wr_fire |=> led_red == $past(flash_phase)
        && !led_green
    ) else $error("red flash does not follow the flash phase");

    a_apb_ready_pulse: assert property (
        st_reg.rsp.pready |=> !st_reg.rsp.pready
    ) else $error("pready held longer than one cycle");

    // Register bus: exactly one wait state, refused accesses leave every setting alone
    a_apb_answer_next: assert property (
        access && !st_reg.rsp.pready |=> st_reg.rsp.pready
    ) else $error("pready not raised in the cycle after the first access edge");

    a_refused_flagged: assert property (
        access && !st_reg.rsp.pready && bad |=> st_reg.rsp.pslverr
        && st_reg.rsp.prdata == 32'h0000_0000
    ) else $error("refused access not flagged with zero read data");

    a_refused_inert: assert property (
        fire && bad |=> $stable(st_reg.inv) && $stable(st_reg.en) && $stable(st_reg.latch)
        && $stable(st_reg.ack_sel) && $stable(st_reg.act) && $stable(st_reg.inact)
    ) else $error("refused access changed a setting");

    a_err_with_ready: assert property (
        st_reg.rsp.pslverr |-> st_reg.rsp.pready
    ) else $error("pslverr raised outside the answer cycle");

    a_green_flash: assert property ( // see RULE_08
        ind && st_reg.act == LIL_GREEN_FLASH && !wr_fire |=> led_green == $past(flash_phase)
        && !led_red
    ) else $error("green flash does not follow the flash phase");

    a_inactive_flash: assert property ( // see RULE_07
        !ind && st_reg.inact == LIL_RED_FLASH && !wr_fire |=> led_red == $past(flash_phase)
        && !led_green
    ) else $error("inactive red flash does not follow the flash phase");

    a_spare_code_dark: assert property ( // see RULE_07
        !ind && 3'(st_reg.inact) > 3'h4 && !wr_fire |=> !led_green && !led_red
    ) else $error("spare inactive colour code lit the lamp");

    a_no_hold_unlatched: assert property ( // see RULE_05
        !st_reg.latch |=> !st_reg.held
    ) else $error("indication held while latching is off");

    a_led_exclusive: assert property ( // see RULE_06
        !(led_green && led_red)
    ) else $error("both lamp colours driven at once");

    a_ack_unselected: assert property ( // see RULE_05
        st_reg.latch && st_reg.held && st_reg.ack_sel == 3'h2 && !ack_in[1] && !wr_fire
        |=> st_reg.held
    ) else $error("acknowledge from an unselected source cleared the indication");

    c_latch_ack: cover property (st_reg.latch && st_reg.held && !or_now && ack_evt);
    c_ack_ignored: cover property (st_reg.latch && st_reg.held && or_now && ack_evt);
    c_flash_on: cover property (ind && st_reg.act == LIL_GREEN_FLASH && flash_phase);
    c_apb_error: cover property (fire && bad);

endmodule
`default_nettype wire

// file: src/lil_cfg.svh
// Register map, field positions, reset values and timing counts of the LED indicator
`ifndef LIL_CFG_SVH
`define LIL_CFG_SVH

`define LIL_NSIG            5
`define LIL_NACK            4
`define LIL_ACK_SEL_W       3

`define LIL_CTRL_OFS        8'h00
`define LIL_COLOR_OFS       8'h04
`define LIL_STAT_OFS        8'h08

`define LIL_CTRL_INV_LSB    0
`define LIL_CTRL_EN_LSB     8
`define LIL_CTRL_LATCH_BIT  16
`define LIL_CTRL_ACK_LSB    20
`define LIL_COLOR_ACT_LSB   0
`define LIL_COLOR_INACT_LSB 4
`define LIL_STAT_SIG_LSB    8
`define LIL_STAT_OR_BIT     0
`define LIL_STAT_HELD_BIT   1
`define LIL_STAT_IND_BIT    2
`define LIL_STAT_GREEN_BIT  3
`define LIL_STAT_RED_BIT    4
`define LIL_STAT_FLASH_BIT  5

`define LIL_INV_RST         5'h00
`define LIL_EN_RST          5'h1F
`define LIL_LATCH_RST       1'b0
`define LIL_ACK_SEL_RST     3'h0

`define LIL_CLK_PERIOD_NS   4
`define LIL_FLASH_HALF_US   250000
`define LIL_FLASH_HALF_CYC  ((`LIL_FLASH_HALF_US * 1000) / `LIL_CLK_PERIOD_NS)

`endif

// file: src/lil_pkg.sv
// Types shared by the LED indicator files
`include "lil_cfg.svh"
package lil_pkg;

    typedef enum logic [2:0] {
        LIL_OFF,
        LIL_GREEN,
        LIL_RED,
        LIL_RED_FLASH,
        LIL_GREEN_FLASH
    } lil_color_t;

    typedef struct packed {
        logic [7:0]  paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } lil_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } lil_apb_rsp_t;

    typedef struct packed {
        logic [`LIL_NSIG-1:0]     inv;
        logic [`LIL_NSIG-1:0]     en;
        logic                     latch;
        logic [`LIL_ACK_SEL_W-1:0] ack_sel;
        lil_color_t               act;
        lil_color_t               inact;
        logic                     held;
        logic                     ack_prev;
        logic                     green;
        logic                     red;
        lil_apb_rsp_t             rsp;
    } lil_state_t;

    typedef struct packed {
        logic [31:0] cnt;
        logic        phase;
    } lil_div_state_t;

endpackage

// file: src/lil_flash_div.sv
// Flash phase generator: square wave from the system clock
`timescale 1ns/1ns
`default_nettype none
`include "lil_cfg.svh"
module lil_flash_div #(
    parameter int unsigned HALF_CYC = `LIL_FLASH_HALF_CYC
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    output logic      phase
);
    import lil_pkg::*;

    lil_div_state_t st_reg;
    lil_div_state_t st_next;
    logic           wrap;

    // Equal halves give the fifty percent duty cycle
    assign wrap = (st_reg.cnt == 32'(HALF_CYC - 1)); // see RULE_08

    always_comb begin
        st_next = st_reg;
        if (wrap) begin
            st_next.cnt   = 32'h0000_0000;
            st_next.phase = ~st_reg.phase; // see RULE_08
        end else begin
            st_next.cnt = st_reg.cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign phase = st_reg.phase;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_flash_toggle_point: assert property ( // see RULE_08
        $changed(st_reg.phase) |-> $past(st_reg.cnt) == 32'(HALF_CYC - 1)
    ) else $error("flash phase toggled off the divider wrap point");

    a_flash_count_range: assert property ( // see RULE_08
        st_reg.cnt < 32'(HALF_CYC)
    ) else $error("flash divider counter ran past its half period");

    c_flash_toggle: cover property (wrap ##1 $changed(st_reg.phase));

endmodule
`default_nettype wire

// file: verification/test_led_indicator_logic.sv
// Self-checking bench for the LED indicator: APB set-up, lamp colours, latch and acknowledge
`timescale 1ns/1ns
`default_nettype none
`include "lil_cfg.svh"
module test_led_indicator_logic;
    import lil_pkg::*;
    // Short flash half period keeps the run small; counts below scale with it
    localparam int unsigned HALF  = 4;
    localparam int          LIMIT = 5000;
    logic                 ref_clk;
    logic                 rst_n;
    lil_apb_req_t         apb_req;
    lil_apb_rsp_t         apb_rsp;
    logic [`LIL_NSIG-1:0] sig_in;
    logic [`LIL_NACK-1:0] ack_in;
    logic                 led_green;
    logic                 led_red;
    lil_apb_rsp_t         apb_rsp_b;
    logic                 led_green_b;
    logic                 led_red_b;
    int                   n_mismatch;
    int                   checked;
    int                   cycles;
    logic [31:0]          rd;
    logic                 err;

    lil_top #(.GROUP_B(1'b0), .HALF_CYC(HALF)) DUT (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .apb_req   (apb_req),
        .apb_rsp   (apb_rsp),
        .sig_in    (sig_in),
        .ack_in    (ack_in),
        .led_green (led_green),
        .led_red   (led_red)
    );

    // Group B twin shares every input; only its reset colour differs
    lil_top #(.GROUP_B(1'b1), .HALF_CYC(HALF)) DUT_B (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .apb_req   (apb_req),
        .apb_rsp   (apb_rsp_b),
        .sig_in    (sig_in),
        .ack_in    (ack_in),
        .led_green (led_green_b),
        .led_red   (led_red_b)
    );

    initial ref_clk = 1'b0;
    always #2 ref_clk = ~ref_clk;

    task automatic end_sim();
        if (n_mismatch == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (cycles == LIMIT) begin
            n_mismatch = n_mismatch + 1;
            end_sim();
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        @(posedge ref_clk);
        apb_req.psel    <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite  <= wr;
        apb_req.paddr   <= addr;
        apb_req.pwdata  <= wdata;
        @(posedge ref_clk);
        apb_req.penable <= 1'b1;
        // Ends once pready is sampled high; the bench cycle ceiling ends a hung wait
        do begin
            @(posedge ref_clk);
        end while (apb_rsp.pready !== 1'b1);
        rd  = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic drive(input logic [`LIL_NSIG-1:0] s, input logic [`LIL_NACK-1:0] a);
        @(posedge ref_clk);
        sig_in <= s;
        ack_in <= a;
    endtask

    // Counts lit cycles over two full flash periods; any phase gives half for flashing
    task automatic look(input string name, input logic [2:0] code);
        int on_g;
        int on_r;
        on_g = 0;
        on_r = 0;
        repeat (3) @(posedge ref_clk);
        #1;
        for (int k = 0; k < 4 * HALF; k++) begin
            on_g += (led_green === 1'b1);
            on_r += (led_red === 1'b1);
            @(posedge ref_clk);
            #1;
        end
        chk(name, on_g, code == 3'h1 ? 4 * HALF : (code == 3'h4 ? 2 * HALF : 0));
        chk(name, on_r, code == 3'h2 ? 4 * HALF : (code == 3'h3 ? 2 * HALF : 0));
    endtask

    initial begin
        apb_req    = '0;
        sig_in     = '0;
        ack_in     = '0;
        rst_n      = 1'b0;
        n_mismatch = 0;
        checked    = 0;
        cycles     = 0;
        rd         = '0;
        err        = 1'b0;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        apb(1'b0, `LIL_CTRL_OFS, 32'h0);
        chk("ctrl reset", rd, 32'h0000_1F00);
        apb(1'b0, `LIL_COLOR_OFS, 32'h0);
        chk("color reset", rd, 32'h0000_0001);
        chk("color reset b", apb_rsp_b.prdata, 32'h0000_0002);
        look("dark when idle", 3'h0);
        // Refused accesses: unmapped, unaligned, write to read-only status
        apb(1'b0, 8'h0C, 32'h0);
        chk("unmapped err", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        apb(1'b0, 8'h01, 32'h0);
        chk("unaligned err", {31'h0, err}, 32'h1);
        apb(1'b1, `LIL_STAT_OFS, 32'hFFFF_FFFF);
        chk("status write err", {31'h0, err}, 32'h1);
        for (int i = 0; i < `LIL_NSIG; i++) begin
            drive(5'h01 << i, 4'h0);
            look("or input", 3'h1);
            chk("group b red", {30'h0, led_green_b, led_red_b}, 32'h1);
            apb(1'b0, `LIL_STAT_OFS, 32'h0);
            chk("status inputs", rd & 32'h0000_1F01, (32'h1 << (i + 8)) | 32'h1);
        end
        for (int i = 0; i < `LIL_NSIG; i++) begin
            apb(1'b1, `LIL_CTRL_OFS, 32'h0000_1F00 | (32'h1 << i));
            drive(5'h00, 4'h0);
            look("inverted low", 3'h1);
            drive(5'h01 << i, 4'h0);
            look("inverted high", 3'h0);
        end
        apb(1'b1, `LIL_CTRL_OFS, 32'h0000_1F00);
        for (int c = 1; c <= 5; c++) begin
            apb(1'b1, `LIL_COLOR_OFS, 32'(c));
            drive(5'h04, 4'h0);
            look("active colour", 3'(c));
            apb(1'b1, `LIL_COLOR_OFS, 32'(c) << 4);
            drive(5'h00, 4'h0);
            look("inactive colour", 3'(c));
        end
        // Latch on, acknowledge from the second source
        apb(1'b1, `LIL_COLOR_OFS, 32'h0000_0001);
        apb(1'b1, `LIL_CTRL_OFS, 32'h0021_1F00);
        drive(5'h01, 4'h0);
        drive(5'h00, 4'h0);
        look("held after pulse", 3'h1);
        apb(1'b0, `LIL_STAT_OFS, 32'h0);
        chk("held flag set", rd & 32'h2, 32'h2);
        drive(5'h01, 4'h2);
        drive(5'h00, 4'h0);
        look("ack while present", 3'h1);
        drive(5'h00, 4'h1);
        look("ack other source", 3'h1);
        drive(5'h00, 4'h0);
        drive(5'h00, 4'h2);
        look("acknowledged", 3'h0);
        apb(1'b0, `LIL_STAT_OFS, 32'h0);
        chk("held flag clear", rd & 32'h2, 32'h0);
        // Latch off: indication follows the inputs, acknowledge is inert
        apb(1'b1, `LIL_CTRL_OFS, 32'h0020_1F00);
        drive(5'h01, 4'h0);
        drive(5'h00, 4'h0);
        look("no latch follows", 3'h0);
        drive(5'h01, 4'h0);
        drive(5'h01, 4'h2);
        look("ack without latch", 3'h1);
        drive(5'h00, 4'h0);
        look("released", 3'h0);
        // Mid-run reset must bring back the control defaults and the group B colour default
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        apb(1'b0, `LIL_CTRL_OFS, 32'h0);
        chk("ctrl after reset", rd, 32'h0000_1F00);
        apb(1'b0, `LIL_COLOR_OFS, 32'h0);
        chk("color after reset b", apb_rsp_b.prdata, 32'h0000_0002);
        end_sim();
    end
endmodule
`default_nettype wire
